// File: verif/scb_remote_tx.sv
`timescale 1ns/1ps
module scb_remote_tx #(
  // One bit is 16 ticks of 4 clocks at the fastest rate
  parameter int bit_clks = 64
) (
  // Bit timing clock
  input wire logic clk,
  // Serial line, idle high
  output logic line
);
  initial line = 1'b1;
  task send(input logic [8:0] d, input int nbits, input logic stop);
    int k;
    line <= 1'b0;
    repeat (bit_clks) @(posedge clk);
    for (k = 0; k <= nbits; k++) begin
      line <= (k == nbits) ? stop : d[k];
      repeat (bit_clks) @(posedge clk);
    end
    // Trailing ones end the frame and let a later break count again
    line <= 1'b1;
    repeat (bit_clks) @(posedge clk);
  endtask : send
  task glitch(input int len);
    line <= 1'b0;
    repeat (len) @(posedge clk);
    line <= 1'b1;
  endtask : glitch
endmodule : scb_remote_tx

// File: verif/scb_serial_checker.sv
`timescale 1ns/1ps
module scb_serial_checker (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // Serial side
  input wire logic RECEIVE_DATA_PIN,
  input wire logic CRYSTAL_CLOCK_BUFFERED,
  input wire logic [7:0] TX_DATA,
  input wire logic TX_LOAD,
  input wire logic BAUD_TICK16
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  logic mapped;
  logic wr_db;
  logic [7:0] last_wr;
  // Six word registers from 0x0c to 0x20
  assign mapped = PADDR[1:0] == 2'h0 && PADDR >= 8'h0c && PADDR <= 8'h20;
  assign wr_db = PSEL && PENABLE && PREADY && PWRITE && PADDR == scb_pkg::OFF_DATA_BUFFER;
  always_ff @(posedge CLK) if (wr_db) last_wr <= PWDATA[7:0];
  ready_wait_a: assert property (PSEL && $rose(PENABLE) |=> PREADY)
    else $error("ready late");
  ready_pulse_a: assert property (PREADY |=> !PREADY)
    else $error("ready held");
  idle_data_a: assert property (!PREADY |-> PRDATA == 32'h0)
    else $error("stray read data");
  err_map_a: assert property (PREADY |-> PSLVERR == !mapped)
    else $error("bad slave error");
  read_width_a: assert property (PREADY && !PWRITE |-> PRDATA[31:8] == 24'h0)
    else $error("upper bits set");
  load_cause_a: assert property (wr_db |-> ##[1:2] TX_LOAD)
    else $error("no tx load");
  load_data_a: assert property (TX_LOAD |-> TX_DATA == last_wr && !$past(TX_LOAD))
    else $error("bad tx byte");
  tick_space_a: assert property (BAUD_TICK16 |=> !BAUD_TICK16 [*3])
    else $error("ticks too close");
  cover property (TX_LOAD);
  cover property (PREADY && PSLVERR);
  cover property (PREADY && !PWRITE && PADDR == scb_pkg::OFF_STATUS_TWO && PRDATA[1]);
endmodule : scb_serial_checker

bind scb_serial scb_serial_checker u_chk (.CLK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR,
  .PWDATA, .PRDATA, .PREADY, .PSLVERR, .RECEIVE_DATA_PIN, .CRYSTAL_CLOCK_BUFFERED,
  .TX_DATA, .TX_LOAD, .BAUD_TICK16);

// File: verif/test_sci_status_data_baud.sv
`timescale 1ns/1ps
module test_sci_status_data_baud;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, xclk = 1'b0;
  logic [7:0] paddr = 8'h00, tx_data, b;
  logic [31:0] pwdata = 32'h0, prdata, q, n;
  logic pready, pslverr, serr, rxd, tx_load, tick;
  int err_count = 0, checks_done = 0, i;
  always #50 clk = ~clk;
  // 310 ns crystal keeps its rising edges off the bus clock grid
  always #155 xclk = ~xclk;
  scb_serial u_dut (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .RECEIVE_DATA_PIN(rxd), .CRYSTAL_CLOCK_BUFFERED(xclk), .TX_DATA(tx_data),
    .TX_LOAD(tx_load), .BAUD_TICK16(tick));
  scb_remote_tx u_rt (.clk(clk), .line(rxd));
  task stop_test;
    $display("mismatches %0d of %0d checks", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h, want %h", $time, got, exp);
    end
  endtask : chk
  task limit(input logic [31:0] k);
    if (k >= 32'h4e20) begin
      err_count++;
      stop_test();
    end
  endtask : limit
  function automatic logic [31:0] tick_clks(input logic [1:0] p, input logic [2:0] r);
    logic [31:0] pd;
    pd = (p == 2'h3) ? 32'hd : (p == 2'h0) ? 32'h1 : {30'h0, p} + 32'h2;
    return (32'h4 * pd) << r;
  endfunction : tick_clks
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic [31:0] k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 32'h0;
    // Ready, data and error are taken at the rising edge that completes the access
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 32'h4e20);
    limit(k);
    q = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q & m, x);
  endtask : rd
  // First pass only lines up on a tick, the second measures a full gap
  task gap;
    repeat (2) begin
      n = 32'h0;
      do begin
        @(negedge clk);
        n++;
      end while (tick !== 1'b1 && n < 32'h4e20);
    end
    limit(n);
    @(posedge clk);
  endtask : gap
  initial begin
    void'($urandom(32'hdc3c1eb4));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(8'h1c, 32'hff, 32'h0);
    rd(8'h14, 32'hff, 32'h0);
    apb(1'b1, 8'h14, 32'h3);
    rd(8'h14, 32'hff, 32'h0);
    apb(1'b0, 8'h04, 32'h0);
    chk({31'h0, serr}, 32'h1);
    for (i = 0; i < 5; i++) begin
      b = (i < 4) ? {2'h0, i[1:0], 1'b0, 3'($urandom % 4)} : 8'h37;
      apb(1'b1, 8'h1c, {24'h0, b});
      rd(8'h1c, 32'hff, {24'h0, b});
      gap;
      chk(n, tick_clks(b[5:4], b[2:0]));
    end
    apb(1'b1, 8'h20, 32'h1);
    apb(1'b1, 8'h1c, 32'h0);
    gap;
    chk({31'h0, n inside {32'hc, 32'hd}}, 32'h1);
    apb(1'b1, 8'h20, 32'h0);
    b = 8'($urandom);
    u_rt.send({1'b0, b}, 8, 1'b1);
    rd(8'h10, 32'h22, 32'h20);
    rd(8'h18, 32'hff, {24'h0, b});
    rd(8'h0c, 32'h80, {24'h0, b[7], 7'h0});
    apb(1'b1, 8'h18, {24'h0, ~b});
    @(negedge clk);
    chk({24'h0, tx_data}, {24'h0, ~b});
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(8'h18, 32'hff, {24'h0, b});
    u_rt.glitch(12);
    rd(8'h14, 32'h1, 32'h1);
    repeat (100) @(posedge clk);
    rd(8'h14, 32'h1, 32'h0);
    apb(1'b1, 8'h20, 32'h2);
    b = 8'($urandom);
    u_rt.send({1'b1, b}, 9, 1'b1);
    rd(8'h0c, 32'h80, 32'h80);
    rd(8'h18, 32'hff, {24'h0, b});
    u_rt.send(9'h0, 9, 1'b0);
    rd(8'h0c, 32'h80, 32'h0);
    rd(8'h10, 32'h22, 32'h22);
    apb(1'b0, 8'h18, 32'h0);
    rd(8'h14, 32'h2, 32'h2);
    apb(1'b0, 8'h18, 32'h0);
    repeat (2000) @(posedge clk);
    rd(8'h14, 32'h3, 32'h0);
    u_rt.send(9'h0, 9, 1'b0);
    rd(8'h14, 32'h2, 32'h2);
    stop_test();
  end
endmodule : test_sci_status_data_baud

// File: verilog/scb_baud_gen.sv
`timescale 1ns/1ps
module scb_baud_gen (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Crystal clock, asynchronous to clk
  input wire logic xclk,
  // Divisor settings and slot tick
  scb_baud_if.gen bif
);

  typedef struct packed {
    logic xclk_meta;
    logic xclk_sync;
    logic xclk_prev;
    logic [12:0] cnt;
    logic tick;
  } scb_baud_s;

  scb_baud_s r;
  scb_baud_s n;
  logic [3:0] pd;
  logic [12:0] limit;
  logic src_edge;

  always_comb begin
    n = r;
    n.xclk_meta = xclk;
    n.xclk_sync = r.xclk_meta;
    n.xclk_prev = r.xclk_sync;
    n.tick = 1'b0;
    case (bif.prescale_code)
      2'b00: pd = scb_pkg::PD_CODE0;
      2'b01: pd = scb_pkg::PD_CODE1;
      2'b10: pd = scb_pkg::PD_CODE2;
      default: pd = scb_pkg::PD_CODE3;
    endcase
    // 64*PD*BD source clocks per bit means 4*PD*BD per slot
    limit = (13'(pd) << scb_pkg::SLOT_SHIFT) << bif.rate_code;
    limit = limit - 13'h1;
    // Crystal must run below half the bus clock to be seen edge by edge
    src_edge = bif.src_sel ? (r.xclk_sync & ~r.xclk_prev) : 1'b1;
    if (src_edge) begin
      if (r.cnt >= limit) begin
        n.cnt = 13'h0;
        n.tick = 1'b1;
      end else begin
        n.cnt = r.cnt + 13'h1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign bif.tick16 = r.tick;

endmodule : scb_baud_gen

// File: verilog/scb_baud_if.sv
`timescale 1ns/1ps
interface scb_baud_if;
  logic [1:0] prescale_code;
  logic [2:0] rate_code;
  logic src_sel;
  logic tick16;

  modport ctrl (output prescale_code, output rate_code, output src_sel, input tick16);
  modport gen (input prescale_code, input rate_code, input src_sel, output tick16);
endinterface : scb_baud_if

// File: verilog/scb_pkg.sv
package scb_pkg;

  // Register byte offsets on the APB word map
  localparam logic [7:0] OFF_CONTROL_THREE = 8'h0c;
  localparam logic [7:0] OFF_STATUS_ONE = 8'h10;
  localparam logic [7:0] OFF_STATUS_TWO = 8'h14;
  localparam logic [7:0] OFF_DATA_BUFFER = 8'h18;
  localparam logic [7:0] OFF_RATE_SELECT = 8'h1c;
  localparam logic [7:0] OFF_CONFIG_TWO = 8'h20;

  // Field positions
  localparam int BIT_RX_NINTH = 7;
  localparam int BIT_RX_FULL = 5;
  localparam int BIT_FRAME_ERROR = 1;
  localparam int BIT_BREAK_SEEN = 1;
  localparam int BIT_RX_ACTIVE = 0;
  localparam int BIT_CLK_SRC = 0;
  localparam int BIT_NINE_MODE = 1;
  localparam int POS_PRESCALE = 4;
  localparam int POS_RATE = 0;

  // Reset values
  localparam logic [1:0] RST_PRESCALE = 2'h0;
  localparam logic [2:0] RST_RATE = 3'h0;
  localparam logic RST_CLK_SRC = 1'b0;
  localparam logic RST_NINE_MODE = 1'b0;

  // Prescaler divisors for codes 00, 01, 10, 11
  localparam logic [3:0] PD_CODE0 = 4'h1;
  localparam logic [3:0] PD_CODE1 = 4'h3;
  localparam logic [3:0] PD_CODE2 = 4'h4;
  localparam logic [3:0] PD_CODE3 = 4'hd;

  // Source clocks per 16x slot: 64 / 16
  localparam logic [1:0] SLOT_SHIFT = 2'h2;

  // Receiver timing in 16x slots
  localparam logic [3:0] SLOT_MID = 4'h7;
  localparam logic [3:0] SLOT_LAST = 4'hf;
  localparam logic [7:0] IDLE_SLOTS_8 = 8'ha0;
  localparam logic [7:0] IDLE_SLOTS_9 = 8'hb0;

  typedef enum logic [1:0] {
    RX_SEARCH = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b10,
    RX_STOP = 2'b11
  } scb_rx_e;

endpackage : scb_pkg

// File: verilog/scb_serial.sv
//Contract
// - Set break-seen flag when a break character arrives on the receive pin.
// - A break also sets frame-error and receiver-full flags.
// - In 9-bit mode a break clears the received ninth bit.
// - Break-seen flag never raises an interrupt; software polls it.
// - Break-seen clears after status-two read with it set, then data read.
// - After clearing, break-seen re-arms only after ones then another break.
// - Reset clears the break-seen flag.
// - Set rx-active when the first slot of the start search sees zero.
// - Rx-active is read-only and never raises an interrupt.
// - Clear rx-active on a false start bit or an idle character.
// - Data register read gives received byte; write gives byte to send.
// - Reset leaves the data register contents unchanged.
// - One rate register sets the bit rate for receiver and transmitter.
// - Prescale code 00..11 selects divisor 1, 3, 4 or 13.
// - Rate code selects divisor two to the code, 1 to 128.
// - Reset clears the prescale and rate codes.
// - Bit rate is source divided by 64 times both divisors.
// - Source clock is bus clock or crystal clock, chosen by config bit.
`timescale 1ns/1ps
module scb_serial (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Serial pins and clocks
  input wire logic RECEIVE_DATA_PIN,
  input wire logic CRYSTAL_CLOCK_BUFFERED,
  // Transmitter hand-off
  output logic [7:0] TX_DATA,
  output logic TX_LOAD,
  // Shared bit-rate slot tick for the transmitter
  output logic BAUD_TICK16
);

  // The state type must exist before the struct that holds it
  typedef scb_pkg::scb_rx_e scb_rx_state_t;

  typedef struct packed {
    logic rxd_meta;
    logic rxd_sync;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [7:0] tx_data;
    logic tx_load;
    logic tick16;
    logic [1:0] prescale_code;
    logic [2:0] rate_code;
    logic clk_src;
    logic nine_mode;
    logic rx_full_flag;
    logic frame_error_flag;
    logic break_seen_flag;
    logic rx_active_flag;
    logic rx_ninth_bit;
    logic arm_full;
    logic arm_frame;
    logic arm_break;
    logic break_armed;
    scb_rx_state_t rx_state;
    logic [3:0] slot;
    logic [3:0] bit_cnt;
    logic [8:0] shift;
    logic [7:0] ones_cnt;
  } scb_serial_s;

  scb_serial_s r;
  scb_serial_s n;
  logic [7:0] rx_data_reg;
  logic [7:0] rx_data_next;
  logic rx_load;
  logic access;
  logic rd_status_one;
  logic rd_status_two;
  logic rd_data;
  logic wr_data;
  logic wr_rate;
  logic wr_config;
  logic [3:0] last_bit;
  logic [7:0] idle_limit;
  logic all_zero;

  scb_baud_if bif ();

  scb_baud_gen u_baud (
    .clk(CLK),
    .rst(RST),
    .xclk(CRYSTAL_CLOCK_BUFFERED),
    .bif(bif)
  );

  // One rate generator serves both directions
  assign bif.prescale_code = r.prescale_code;
  assign bif.rate_code = r.rate_code;
  assign bif.src_sel = r.clk_src;

  always_comb begin
    n = r;
    rx_load = 1'b0;
    rx_data_next = rx_data_reg;
    all_zero = 1'b0;
    n.rxd_meta = RECEIVE_DATA_PIN;
    n.rxd_sync = r.rxd_meta;
    n.tick16 = bif.tick16;
    n.tx_load = 1'b0;

    // APB: one wait state, answer registered
    n.pready = PSEL & PENABLE & ~r.pready;
    n.prdata = 32'h0;
    n.pslverr = 1'b0;
    if (n.pready) begin
      case (PADDR)
        scb_pkg::OFF_CONTROL_THREE: n.prdata[scb_pkg::BIT_RX_NINTH] = r.rx_ninth_bit;
        scb_pkg::OFF_STATUS_ONE: begin
          n.prdata[scb_pkg::BIT_RX_FULL] = r.rx_full_flag;
          n.prdata[scb_pkg::BIT_FRAME_ERROR] = r.frame_error_flag;
        end
        scb_pkg::OFF_STATUS_TWO: begin
          // Polled only: no request line leaves this block
          n.prdata[scb_pkg::BIT_BREAK_SEEN] = r.break_seen_flag;
          n.prdata[scb_pkg::BIT_RX_ACTIVE] = r.rx_active_flag;
        end
        scb_pkg::OFF_DATA_BUFFER: n.prdata[7:0] = rx_data_reg;
        scb_pkg::OFF_RATE_SELECT: begin
          n.prdata[scb_pkg::POS_PRESCALE +: 2] = r.prescale_code;
          n.prdata[scb_pkg::POS_RATE +: 3] = r.rate_code;
        end
        scb_pkg::OFF_CONFIG_TWO: begin
          n.prdata[scb_pkg::BIT_CLK_SRC] = r.clk_src;
          n.prdata[scb_pkg::BIT_NINE_MODE] = r.nine_mode;
        end
        default: n.pslverr = 1'b1;
      endcase
    end

    // Effects happen only at the completing edge
    access = PSEL & PENABLE & r.pready;
    rd_status_one = access & ~PWRITE & (PADDR == scb_pkg::OFF_STATUS_ONE);
    rd_status_two = access & ~PWRITE & (PADDR == scb_pkg::OFF_STATUS_TWO);
    rd_data = access & ~PWRITE & (PADDR == scb_pkg::OFF_DATA_BUFFER);
    wr_data = access & PWRITE & (PADDR == scb_pkg::OFF_DATA_BUFFER);
    wr_rate = access & PWRITE & (PADDR == scb_pkg::OFF_RATE_SELECT);
    wr_config = access & PWRITE & (PADDR == scb_pkg::OFF_CONFIG_TWO);

    // Write half of the data buffer goes to the transmitter
    if (wr_data) begin
      n.tx_data = PWDATA[7:0];
      n.tx_load = 1'b1;
    end
    if (wr_rate) begin
      n.prescale_code = PWDATA[scb_pkg::POS_PRESCALE +: 2];
      n.rate_code = PWDATA[scb_pkg::POS_RATE +: 3];
    end
    if (wr_config) begin
      n.clk_src = PWDATA[scb_pkg::BIT_CLK_SRC];
      n.nine_mode = PWDATA[scb_pkg::BIT_NINE_MODE];
    end

    // Two-step clear: status read arms, data read clears armed flags
    if (rd_data) begin
      if (r.arm_full) n.rx_full_flag = 1'b0;
      if (r.arm_frame) n.frame_error_flag = 1'b0;
      if (r.arm_break) n.break_seen_flag = 1'b0;
      n.arm_full = 1'b0;
      n.arm_frame = 1'b0;
      n.arm_break = 1'b0;
    end
    if (rd_status_one) begin
      n.arm_full = r.rx_full_flag;
      n.arm_frame = r.frame_error_flag;
    end
    if (rd_status_two) begin
      n.arm_break = r.break_seen_flag;
    end

    // Ones on the line re-arm break detection
    if (r.rxd_sync) begin
      n.break_armed = 1'b1;
    end

    last_bit = r.nine_mode ? 4'h8 : 4'h7;
    idle_limit = r.nine_mode ? scb_pkg::IDLE_SLOTS_9 : scb_pkg::IDLE_SLOTS_8;

    if (r.tick16) begin
      n.slot = r.slot + 4'h1;
      case (r.rx_state)
        scb_pkg::RX_SEARCH: begin
          n.slot = 4'h1;
          if (!r.rxd_sync) begin
            // This tick is the first slot of the start bit
            n.rx_active_flag = 1'b1;
            n.ones_cnt = 8'h0;
            n.rx_state = scb_pkg::RX_START;
          end else if (r.ones_cnt != idle_limit) begin
            n.ones_cnt = r.ones_cnt + 8'h1;
            if (n.ones_cnt == idle_limit) begin
              n.rx_active_flag = 1'b0;
            end
          end
        end
        scb_pkg::RX_START: begin
          if (r.slot == scb_pkg::SLOT_MID && r.rxd_sync) begin
            // Start bit gone high by mid-bit: noise or wrong rate
            n.rx_active_flag = 1'b0;
            n.rx_state = scb_pkg::RX_SEARCH;
          end else if (r.slot == scb_pkg::SLOT_LAST) begin
            n.bit_cnt = 4'h0;
            n.rx_state = scb_pkg::RX_DATA;
          end
        end
        scb_pkg::RX_DATA: begin
          if (r.slot == scb_pkg::SLOT_MID) begin
            n.shift = {r.rxd_sync, r.shift[8:1]};
          end
          if (r.slot == scb_pkg::SLOT_LAST) begin
            n.bit_cnt = r.bit_cnt + 4'h1;
            if (r.bit_cnt == last_bit) begin
              n.rx_state = scb_pkg::RX_STOP;
            end
          end
        end
        scb_pkg::RX_STOP: begin
          // Return to search at mid stop bit so a short stop bit still resyncs
          if (r.slot == scb_pkg::SLOT_MID) begin
            n.rx_state = scb_pkg::RX_SEARCH;
            n.ones_cnt = 8'h0;
            rx_load = 1'b1;
            rx_data_next = r.nine_mode ? r.shift[7:0] : r.shift[8:1];
            n.rx_ninth_bit = r.nine_mode ? r.shift[8] : r.shift[8];
            n.rx_full_flag = 1'b1;
            if (!r.rxd_sync) begin
              n.frame_error_flag = 1'b1;
            end
            all_zero = (r.shift == 9'h0) || (!r.nine_mode && r.shift[8:1] == 8'h0);
            if (!r.rxd_sync && all_zero && r.break_armed) begin
              n.break_seen_flag = 1'b1;
              n.frame_error_flag = 1'b1;
              n.rx_full_flag = 1'b1;
              n.break_armed = 1'b0;
              if (r.nine_mode) begin
                n.rx_ninth_bit = 1'b0;
              end
            end
          end
        end
        default: n.rx_state = scb_pkg::RX_SEARCH;
      endcase
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      r <= '0;
      r.prescale_code <= scb_pkg::RST_PRESCALE;
      r.rate_code <= scb_pkg::RST_RATE;
      r.clk_src <= scb_pkg::RST_CLK_SRC;
      r.nine_mode <= scb_pkg::RST_NINE_MODE;
      r.break_seen_flag <= 1'b0;
      r.break_armed <= 1'b1;
      r.rxd_meta <= 1'b1;
      r.rxd_sync <= 1'b1;
      r.rx_state <= scb_pkg::RX_SEARCH;
    end else begin
      r <= n;
    end
  end

  // Receive half keeps its byte through reset, so it has no reset branch
  always_ff @(posedge CLK) begin
    if (rx_load) begin
      rx_data_reg <= rx_data_next;
    end
  end

  assign PRDATA = r.prdata;
  assign PREADY = r.pready;
  assign PSLVERR = r.pslverr;
  assign TX_DATA = r.tx_data;
  assign TX_LOAD = r.tx_load;
  assign BAUD_TICK16 = r.tick16;

endmodule : scb_serial
